// file: logic/tof_cfg.svh
/*
  Constants for the thermal and over-power fault block: register offsets,
  field positions, reset values and timing figures. Assumes a 250 MHz hclk.
*/
`ifndef TOF_CFG_SVH
`define TOF_CFG_SVH
`define TOF_CLK_MHZ          250
`define TOF_NTC_DLY_NS       50000
`define TOF_NTC_DLY_CYC      ((`TOF_NTC_DLY_NS * `TOF_CLK_MHZ + 999) / 1000)
`define TOF_INPUT_OVERVOLTAGE_FAULT_DLY_NS      750000
`define TOF_INPUT_OVERVOLTAGE_FAULT_DLY_CYC     ((`TOF_INPUT_OVERVOLTAGE_FAULT_DLY_NS * `TOF_CLK_MHZ + 999) / 1000)
`define TOF_OPP_DLY_MS       160
`define TOF_OPP_DLY_CYC      (`TOF_OPP_DLY_MS * `TOF_CLK_MHZ * 1000)
`define TOF_FDR_DLY_MS       1500
`define TOF_FDR_DLY_CYC      (`TOF_FDR_DLY_MS * `TOF_CLK_MHZ * 1000)
`define TOF_CS_OTP_CYCLES    2'h2
`define TOF_ADDR_CTRL        8'h00
`define TOF_ADDR_STAT        8'h04
`define TOF_ADDR_LCGAIN      8'h08
`define TOF_CTRL_RESET       32'h0000_0000
`define TOF_LCGAIN_RESET     8'h10
`define TOF_CTRL_CFG_LSB     0
`define TOF_CTRL_LATCH_BIT   2
`define TOF_OPP_TOP_MV       12'h258
`define TOF_VS_HI_MV         12'h9C4
`define TOF_VS_LO_MV         12'h960
`endif

// file: logic/tof_pkg.sv
/*
  Types for the thermal and over-power fault block.
  Takes none of its numbers from tof_cfg.svh; the encodings are set here.
*/
package tof_pkg;
  typedef enum logic [1:0] {
    TOF_CFG_FLT_NTC  = 2'b00,
    TOF_CFG_FLT_DIV  = 2'b01,
    TOF_CFG_CS_HIGH  = 2'b10,
    TOF_CFG_CS_PMOS  = 2'b11
  } tof_cfg_type;
  typedef enum logic [1:0] {
    TOF_ST_RUN   = 2'b00,
    TOF_ST_RECOV = 2'b01,
    TOF_ST_LATCH = 2'b10,
    TOF_ST_WAIT  = 2'b11
  } tof_state_type;
endpackage : tof_pkg

// file: logic/tof_qual_timer.sv
/*
  Qualification timer: counts while a condition holds and flags when the
  condition has held for LIMIT cycles. Assumes a synchronous condition.
*/
`timescale 1ns/100ps
`default_nettype none
module tof_qual_timer #(
  parameter int unsigned LIMIT = 16
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic cond,
  output logic      expired
);
  typedef struct packed {
    logic [31:0] cnt;
    logic        exp;
  } tof_qt_type;
  tof_qt_type st_q;
  tof_qt_type st_d;

  // Clears when the condition drops, so short excursions never accumulate.
  always_comb
  begin
    st_d = st_q;
    if (!cond)
    begin
      st_d.cnt = 32'h0000_0000;
      st_d.exp = 1'b0;
    end
    else if (st_q.cnt >= LIMIT - 1)
      st_d.exp = 1'b1;
    else
      st_d.cnt = st_q.cnt + 32'h0000_0001;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign expired = st_q.exp;
endmodule : tof_qual_timer
`default_nettype wire

// file: logic/tof_fault_top.sv
/*
  Thermal and over-power fault qualification for an active-clamp flyback
  controller, with an AHB-Lite register slave. Analog comparators arrive as
  asynchronous inputs and are synchronised here; hresetn is the supply reset.
*/
// Chosen here: the AHB-Lite interface to the registers and the address map.
`include "tof_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tof_fault_top #(
  parameter int unsigned NTC_CYC  = `TOF_NTC_DLY_CYC,
  parameter int unsigned INPUT_OVERVOLTAGE_FAULT_CYC = `TOF_INPUT_OVERVOLTAGE_FAULT_DLY_CYC,
  parameter int unsigned OPP_CYC  = `TOF_OPP_DLY_CYC,
  parameter int unsigned FDR_CYC  = `TOF_FDR_DLY_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        fault_sense_low,
  input  wire logic        fault_sense_above_clear,
  input  wire logic        fault_sense_above_ovp,
  input  wire logic        cs_above_otp,
  input  wire logic        cs_above_opp,
  input  wire logic        voltage_sense_above_hi,
  input  wire logic        voltage_sense_above_lo,
  input  wire logic        demag_end,
  input  wire logic        supply_off_reached,
  input  wire logic        light_load_mode,
  input  wire logic        burst_wait,
  input  wire logic        low_side_req,
  input  wire logic        high_side_req,
  input  wire logic [7:0]  line_sense_current,
  output logic             low_side_drive,
  output logic             high_side_drive,
  output logic             run_out,
  output logic             fault_bias_en,
  output logic             clear_level_raised,
  output logic             opp_set_high,
  output logic [11:0]      power_limit_top_threshold,
  output logic [7:0]       line_comp_current,
  output logic             switching_enable
);
  // Ten comparator and pin levels cross into hclk through two flops; light_load_mode and the drive requests do not.
  localparam int NSYNC = 10;

  typedef struct packed {
    logic [NSYNC-1:0]        s1;
    logic [NSYNC-1:0]        s2;
    logic [31:0]             ctrl;
    logic [7:0]              lcgain;
    logic                    dph;
    logic                    dwr;
    logic [7:0]              daddr;
    logic [31:0]             rdata;
    tof_pkg::tof_state_type  fsm;
    logic [31:0]             fdr_cnt;
    logic                    fdr_done;
    logic [1:0]              cs_cnt;
    logic                    cs_seen;
    logic                    ls_prev;
    logic                    otp_flt;
    logic                    otp_cs;
    logic                    input_overvoltage_fault;
    logic                    over_power_fault;
    logic                    vs_hi;
    logic [7:0]              lcc;
    logic                    ls;
    logic                    hs;
  } tof_state_t_type;
  tof_state_t_type st_q;
  tof_state_t_type st_d;

  // Helpers shared by the bus slave and the fault logic.
  logic [NSYNC-1:0] async_in;
  logic             ntc_exp;
  logic             input_overvoltage_fault_exp;
  logic             opp_exp;
  logic             ntc_cond;
  logic             opp_cond;
  tof_pkg::tof_cfg_type cfg;
  logic             latch_off;
  logic             fault_any;
  logic             switching;

  // Bit order fixes the s2 indices below: bit 9 is the trip level, bit 0 the wait.
  assign async_in = {fault_sense_low,
                     fault_sense_above_clear,
                     fault_sense_above_ovp,
                     cs_above_otp,
                     cs_above_opp,
                     voltage_sense_above_hi,
                     voltage_sense_above_lo,
                     demag_end,
                     supply_off_reached,
                     burst_wait};

  // Configuration and fault response come from the control register.
  assign cfg       = tof_pkg::tof_cfg_type'(st_q.ctrl[`TOF_CTRL_CFG_LSB +: 2]);
  assign latch_off = st_q.ctrl[`TOF_CTRL_LATCH_BIT];
  assign switching = (st_q.fsm == tof_pkg::TOF_ST_RUN);

  // Pin thermal qualification only while the bias current is on; the wait state starves it.
  assign ntc_cond = (cfg == tof_pkg::TOF_CFG_FLT_NTC) && st_q.s2[9] && fault_bias_en
                    && switching;
  assign opp_cond = st_q.s2[5] && switching;

  // Pin thermal qualification; any break in the trip level restarts it.
  tof_qual_timer #(.LIMIT(NTC_CYC)) u_ntc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cond    (ntc_cond),
    .expired (ntc_exp)
  );
  // The divider configuration reuses the over-voltage comparator and delay.
  tof_qual_timer #(.LIMIT(INPUT_OVERVOLTAGE_FAULT_CYC)) u_input_overvoltage_fault (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cond    (st_q.s2[7]),
    .expired (input_overvoltage_fault_exp)
  );

  // Over-power run; its long count is why simulation shortens the limit.
  tof_qual_timer #(.LIMIT(OPP_CYC)) u_opp (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cond    (opp_cond),
    .expired (opp_exp)
  );

  // Any held fault flag stops switching at the next edge.
  assign fault_any = st_q.otp_flt | st_q.otp_cs | st_q.input_overvoltage_fault | st_q.over_power_fault;

  // Next state: synchronisers, bus slave, fault flags and the recovery machine.
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    // AHB-Lite: zero wait states, always OKAY; unmapped reads return zero.
    st_d.dph = hsel && hready && htrans[1];
    if (hsel && hready && htrans[1])
    begin
      st_d.dwr   = hwrite;
      st_d.daddr = haddr[7:0];
    end
    // Writes land in the data phase, when hwdata stands.
    if (st_q.dph && st_q.dwr)
    begin
      if (st_q.daddr == `TOF_ADDR_CTRL)
        st_d.ctrl = hwdata & 32'h0000_0007;
      else if (st_q.daddr == `TOF_ADDR_LCGAIN && hwdata[7:0] != 8'h00)
        st_d.lcgain = hwdata[7:0];
    end
    // Read data is registered at the address phase, so it stands in the data phase.
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      case (haddr[7:0])
        `TOF_ADDR_CTRL:   st_d.rdata = st_q.ctrl;
        `TOF_ADDR_STAT:   st_d.rdata = {24'h000000, st_q.vs_hi, st_q.fsm, st_q.over_power_fault,
                                        st_q.input_overvoltage_fault, st_q.otp_cs, st_q.otp_flt, switching};
        `TOF_ADDR_LCGAIN: st_d.rdata = {24'h000000, st_q.lcgain};
        default:          st_d.rdata = 32'h0000_0000;
      endcase
    end

    // Hysteresis band between the two voltage-sense levels.
    if (st_q.s2[4])
      st_d.vs_hi = 1'b1;
    else if (!st_q.s2[3])
      st_d.vs_hi = 1'b0;
    // The zero guard avoids a divide by zero; the bus already refuses a zero gain.
    st_d.lcc = st_q.lcgain == 8'h00 ? 8'h00 : line_sense_current / st_q.lcgain;

    // Low-side follows request only while switching; high-side never overlaps it.
    st_d.ls = low_side_req && switching;
    st_d.hs = high_side_req && switching && !low_side_req && !st_q.ls;

    // Current-sense sampling window: after low-side off, before demag end.
    // One guard cycle after turn-off keeps the switching edge out of the sample.
    st_d.ls_prev = st_q.ls;
    if (cfg[1] && switching)
    begin
      if (!st_q.ls && !st_q.ls_prev && st_q.s2[6]
          && (cfg == tof_pkg::TOF_CFG_CS_PMOS || st_q.hs))
        st_d.cs_seen = 1'b1;
      if (st_q.s2[2] && !st_q.ls)
      begin
        st_d.cs_seen = 1'b0;
        if (st_q.cs_seen)
          st_d.cs_cnt = st_q.cs_cnt + 2'h1;
        else
          st_d.cs_cnt = 2'h0;
      end
      if (st_d.cs_cnt >= `TOF_CS_OTP_CYCLES)
        st_d.otp_cs = 1'b1;
    end

    // Fault-sense thermal fault; auto-recovery clears only above the raised level.
    if (ntc_exp || (cfg == tof_pkg::TOF_CFG_FLT_DIV && input_overvoltage_fault_exp))
      st_d.otp_flt = 1'b1;
    else if (st_q.otp_flt && st_q.s2[8] && st_q.fsm == tof_pkg::TOF_ST_WAIT)
      st_d.otp_flt = 1'b0;
    // In the divider setup the same comparator means heat, not line over-voltage.
    if (cfg != tof_pkg::TOF_CFG_FLT_DIV && input_overvoltage_fault_exp)
      st_d.input_overvoltage_fault = 1'b1;
    else if (!st_q.s2[7] && st_q.fsm == tof_pkg::TOF_ST_WAIT)
      st_d.input_overvoltage_fault = 1'b0;
    // Over-power is only forgotten on a restart out of the wait state.
    if (opp_exp)
      st_d.over_power_fault = 1'b1;

    // Recovery machine: run, timed recovery, wait for a supply cycle, or latch.
    case (st_q.fsm)
      tof_pkg::TOF_ST_RUN:
        if (fault_any)
        begin
          // A thermal fault in the divider configuration never latches.
          if (latch_off && !(st_q.otp_flt && cfg == tof_pkg::TOF_CFG_FLT_DIV))
            st_d.fsm = tof_pkg::TOF_ST_LATCH;
          else
            st_d.fsm = tof_pkg::TOF_ST_RECOV;
          st_d.fdr_cnt  = 32'h0000_0000;
          st_d.fdr_done = 1'b0;
        end
      tof_pkg::TOF_ST_RECOV:
        if (st_q.fdr_cnt >= FDR_CYC - 1)
        begin
          st_d.fsm      = tof_pkg::TOF_ST_WAIT;
          st_d.fdr_done = 1'b1;
        end
        else
          st_d.fdr_cnt = st_q.fdr_cnt + 32'h0000_0001;
      tof_pkg::TOF_ST_WAIT:
        if (st_q.fdr_done && st_q.s2[1] && !st_q.otp_flt && !st_q.input_overvoltage_fault)
        begin
          st_d.fsm    = tof_pkg::TOF_ST_RUN;
          st_d.otp_cs = 1'b0;
          st_d.over_power_fault    = 1'b0;
          st_d.cs_cnt = 2'h0;
        end
      tof_pkg::TOF_ST_LATCH:
        st_d.fsm = tof_pkg::TOF_ST_LATCH;
      default:
        st_d.fsm = tof_pkg::TOF_ST_RUN;
    endcase
  end

  // The supply reset returns everything to run with the register defaults.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q        <= '0;
      st_q.ctrl   <= `TOF_CTRL_RESET;
      st_q.lcgain <= `TOF_LCGAIN_RESET;
    end
    else
      st_q <= st_d;
  end

  // Bias off in light-load wait; saves standby power at the cost of coverage.
  assign fault_bias_en = !(light_load_mode && st_q.s2[0]);
  // The slave never stalls and never answers with an error.
  assign hreadyout                 = 1'b1;
  assign hresp                     = 1'b0;
  assign hrdata                    = st_q.rdata;
  assign low_side_drive            = st_q.ls;
  assign high_side_drive           = st_q.hs;
  assign run_out                   = switching;
  assign switching_enable          = switching;
  assign clear_level_raised        = st_q.otp_flt && !latch_off;
  assign opp_set_high              = st_q.vs_hi;
  assign power_limit_top_threshold = `TOF_OPP_TOP_MV;
  assign line_comp_current         = st_q.lcc;
endmodule : tof_fault_top
`default_nettype wire

// file: verif/tof_fault_assertions.sv
/*
  Port checks for the thermal and over-power fault block.
  Assumes a bind to tof_fault_top; sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module tof_fault_assertions #(
  parameter int unsigned OPP_CYC = 32
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        cs_above_opp,
  input wire logic        voltage_sense_above_hi,
  input wire logic        voltage_sense_above_lo,
  input wire logic        light_load_mode,
  input wire logic        burst_wait,
  input wire logic        low_side_drive,
  input wire logic        high_side_drive,
  input wire logic        fault_bias_en,
  input wire logic        opp_set_high,
  input wire logic        switching_enable,
  input wire logic [11:0] power_limit_top_threshold
);
  logic [7:0] opp_q;
  logic [7:0] opp_d;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Unbroken over-power cycles; it saturates so a long hold cannot wrap round.
  always_comb opp_d = cs_above_opp ? opp_q + {7'h00, opp_q != 8'hFF} : 8'h00;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) opp_q <= 8'h00;
    else opp_q <= opp_d;
  // The margin of six covers two synchroniser flops, the fault flag and the state register.
  property p_hs; low_side_drive |-> !high_side_drive; endproperty
  property p_bias; (light_load_mode && burst_wait) [*3] |-> !fault_bias_en; endproperty
  property p_idle; !switching_enable [*2] |-> !low_side_drive && !high_side_drive; endproperty
  property p_hold; $fell(switching_enable) |=> !switching_enable [*7]; endproperty
  property p_opp; opp_q == 8'(OPP_CYC + 6) |-> !switching_enable; endproperty
  property p_hi; voltage_sense_above_hi [*4] |-> opp_set_high; endproperty
  property p_lo; !voltage_sense_above_lo [*4] |-> !opp_set_high; endproperty
  property p_top; power_limit_top_threshold == 12'h258; endproperty
  a_hs: assert property (p_hs) else $error("high side overlaps low side");
  a_bias: assert property (p_bias) else $error("bias on in wait");
  a_idle: assert property (p_idle) else $error("drive while stopped");
  a_hold: assert property (p_hold) else $error("fault left too soon");
  a_opp: assert property (p_opp) else $error("over-power not qualified");
  a_hi: assert property (p_hi) else $error("high set not chosen");
  a_lo: assert property (p_lo) else $error("low set not chosen");
  a_top: assert property (p_top) else $error("top threshold wrong");
  // Main scenarios: a fault stop, a full over-power run and a set change.
  c_stop: cover property ($fell(switching_enable));
  c_opp: cover property (opp_q == 8'(OPP_CYC));
  c_set: cover property ($rose(opp_set_high));
endmodule : tof_fault_assertions
`default_nettype wire

// file: verif/tof_stage_model.sv
/*
  Model of the sensing network and power-stage timing around the fault block.
  Assumes the bench sets the temperature; a switching cycle is 10 hclk.
*/
`timescale 1ns/100ps
`default_nettype none
module tof_stage_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [1:0] ntc_temp,
  input  wire logic       cs_hot,
  input  wire logic       low_side_drive,
  input  wire logic       fault_bias_en,
  input  wire logic       run_out,
  output logic            fault_sense_low,
  output logic            fault_sense_above_clear,
  output logic            cs_above_otp,
  output logic            demag_end,
  output logic            low_side_req,
  output logic            high_side_req
);
  logic [3:0] phase_q;
  // Low side in phases 0-2, high side 4-6, demagnetisation ends at 8.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) phase_q <= 4'h0;
    else phase_q <= (phase_q == 4'h9) ? 4'h0 : phase_q + 4'h1;
  assign low_side_req  = phase_q < 4'h3;
  assign high_side_req = phase_q inside {[4'h4:4'h6]};
  assign demag_end     = phase_q == 4'h8;
  // Without bias current the pin sits at ground, which reads as a trip.
  assign fault_sense_low         = !fault_bias_en || ntc_temp == 2'h2;
  assign fault_sense_above_clear = fault_bias_en && ntc_temp == 2'h0;
  // The divider is fed by run and biased only once the low side is off.
  assign cs_above_otp = cs_hot && run_out && !low_side_drive;
endmodule : tof_stage_model
`default_nettype wire

// file: verif/tb_tof_fault_top.sv
/*
  Self-checking bench for tof_fault_top: registers, thermal and over-power.
  Assumes the timers are shortened to 8/16/32/64 cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_tof_fault_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic [11:0] top;
  logic [7:0]  lsc = 8'h40;
  logic [7:0]  lcc;
  logic [1:0]  ntc = 2'h0;
  logic        ovp = 1'b0, over_power_fault = 1'b0, vhi = 1'b0, vlo = 1'b0, soff = 1'b0;
  logic        ll = 1'b0, bw = 1'b0, cs_hot = 1'b0;
  logic        rdy, hresp, fsl, fsc, otp, dem, lrq, hrq, lsd, hsd, run, bias, clr, ohi, sw;
  logic [31:0] ra [4] = '{32'h0, 32'h4, 32'h8, 32'hC};
  logic [31:0] rv [4] = '{32'h0, 32'h1, 32'h10, 32'h0};
  int          errors = 0;
  int          tests_run = 0;
  // Half period of the 250 MHz clock.
  always #2 hclk = ~hclk;
  tof_fault_top #(.NTC_CYC(8), .INPUT_OVERVOLTAGE_FAULT_CYC(16), .OPP_CYC(32), .FDR_CYC(64)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hreadyout(rdy),
    .hresp(hresp), .hrdata(hrdata), .fault_sense_low(fsl), .fault_sense_above_clear(fsc),
    .fault_sense_above_ovp(ovp), .cs_above_otp(otp), .cs_above_opp(over_power_fault),
    .voltage_sense_above_hi(vhi), .voltage_sense_above_lo(vlo), .demag_end(dem),
    .supply_off_reached(soff), .light_load_mode(ll), .burst_wait(bw), .low_side_req(lrq),
    .high_side_req(hrq), .line_sense_current(lsc), .low_side_drive(lsd),
    .high_side_drive(hsd), .run_out(run), .fault_bias_en(bias), .clear_level_raised(clr),
    .opp_set_high(ohi), .power_limit_top_threshold(top), .line_comp_current(lcc),
    .switching_enable(sw));
  tof_stage_model i_model (
    .hclk(hclk), .hresetn(hresetn), .ntc_temp(ntc), .cs_hot(cs_hot), .low_side_drive(lsd),
    .fault_bias_en(bias), .fault_sense_low(fsl), .fault_sense_above_clear(fsc),
    .cs_above_otp(otp), .demag_end(dem), .low_side_req(lrq), .high_side_req(hrq),
    .run_out(run));
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic chb(input logic got, input logic exp, input string m);
    chk({31'h0, got}, {31'h0, exp}, m);
  endtask : chb
  // Waits for ready at a rising edge; a bus that never answers ends the run.
  task automatic hold();
    int n;
    @(posedge hclk);
    for (n = 0; rdy !== 1'b1 && n < 50; n++) @(posedge hclk);
    if (n == 50)
    begin
      chk(32'h1, 32'h0, "bus wait limit");
      summarize();
    end
  endtask : hold
  task automatic bus(input logic wr, input logic [31:0] adr, input logic [31:0] wd);
    htrans <= 2'h2;
    hsel   <= 1'b1;
    haddr  <= adr;
    hwrite <= wr;
    hold();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    hold();
    rd = hrdata;
  endtask : bus
  // Bounded wait for the switching state, then compares it.
  task automatic wt(input logic v, input int lim, input string m);
    int n;
    for (n = 0; sw !== v && n < lim; n++) @(posedge hclk);
    chb(sw, v, m);
  endtask : wt
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (ra[i])
      bus(1'b0, ra[i], 32'h0);
    foreach (ra[i])
    begin
      bus(1'b0, ra[i], 32'h0);
      chk(rd, rv[i], "register reset value");
    end
    chb(hresp, 1'b0, "okay response");
    chb(run, 1'b1, "run pin after reset");
    chk({20'h0, top}, 32'h258, "top threshold");
    // Gain 8 turns 0x40 into 8; a zero gain write must be ignored.
    bus(1'b1, 32'h8, 32'h8);
    bus(1'b1, 32'h8, 32'h0);
    repeat (3) @(posedge hclk);
    chk({24'h0, lcc}, 32'h8, "line compensation");
    lsc <= 8'h80;
    repeat (3) @(posedge hclk);
    chk({24'h0, lcc}, 32'h10, "line compensation follows line");
    vhi <= 1'b1;
    vlo <= 1'b1;
    repeat (8) @(posedge hclk);
    vhi <= 1'b0;
    repeat (8) @(posedge hclk);
    chb(ohi, 1'b1, "set kept in band");
    vlo <= 1'b0;
    repeat (8) @(posedge hclk);
    chb(ohi, 1'b0, "low set");
    $display("registers and sets done");
    // Two short trips must each be forgotten; a long one faults.
    repeat (2)
    begin
      ntc <= 2'h2;
      repeat (5) @(posedge hclk);
      ntc <= 2'h0;
      repeat (10) @(posedge hclk);
    end
    chb(sw, 1'b1, "short trip ignored");
    ntc <= 2'h2;
    wt(1'b0, 40, "thermal fault");
    chb(clr, 1'b1, "clear level raised");
    chb(run, 1'b0, "run pin low in fault");
    ntc <= 2'h1;
    soff <= 1'b1;
    repeat (100) @(posedge hclk);
    chb(sw, 1'b0, "warm pin keeps fault");
    ntc <= 2'h0;
    wt(1'b1, 30, "restart after clear");
    soff <= 1'b0;
    $display("pin thermal done");
    ll <= 1'b1;
    bw <= 1'b1;
    ntc <= 2'h2;
    repeat (40) @(posedge hclk);
    chb(bias, 1'b0, "bias off in wait");
    chb(sw, 1'b1, "no trip in wait");
    ntc <= 2'h0;
    ovp <= 1'b1;
    bus(1'b1, 32'h0, 32'h1);
    wt(1'b0, 60, "divider trip in wait");
    ovp <= 1'b0;
    ll <= 1'b0;
    bw <= 1'b0;
    soff <= 1'b1;
    wt(1'b1, 120, "divider recovery");
    soff <= 1'b0;
    $display("light load done");
    // Current-sense trip: one cycle is not enough, two in a row fault.
    bus(1'b1, 32'h0, 32'h2);
    cs_hot <= 1'b1;
    repeat (6) @(posedge hclk);
    cs_hot <= 1'b0;
    repeat (30) @(posedge hclk);
    chb(sw, 1'b1, "single hot cycle");
    cs_hot <= 1'b1;
    wt(1'b0, 40, "two hot cycles");
    cs_hot <= 1'b0;
    soff <= 1'b1;
    repeat (30) @(posedge hclk);
    chb(sw, 1'b0, "recovery delay runs");
    wt(1'b1, 80, "restart after delay");
    bus(1'b1, 32'h0, 32'h6);
    cs_hot <= 1'b1;
    wt(1'b0, 40, "latched trip");
    cs_hot <= 1'b0;
    repeat (150) @(posedge hclk);
    chb(sw, 1'b0, "latch holds");
    soff <= 1'b0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chb(sw, 1'b1, "supply reset frees latch");
    $display("current-sense thermal done");
    // Over-voltage on the sense pin in the pin-thermal setup, then recovery.
    ovp <= 1'b1;
    wt(1'b0, 60, "input over-voltage");
    ovp <= 1'b0;
    soff <= 1'b1;
    wt(1'b1, 120, "over-voltage recovery");
    soff <= 1'b0;
    // Run-fed sensing: trips while run is high and recovers after the delay.
    bus(1'b1, 32'h0, 32'h3);
    cs_hot <= 1'b1;
    wt(1'b0, 40, "run-biased trip");
    chb(run, 1'b0, "sense bias removed");
    cs_hot <= 1'b0;
    soff <= 1'b1;
    wt(1'b1, 120, "run-biased recovery");
    soff <= 1'b0;
    $display("over-voltage and run-biased done");
    // Over-power: a broken run restarts the timer, a full run faults.
    repeat (2)
    begin
      over_power_fault <= 1'b1;
      repeat (20) @(posedge hclk);
      over_power_fault <= 1'b0;
      repeat (5) @(posedge hclk);
    end
    chb(sw, 1'b1, "broken over-power");
    over_power_fault <= 1'b1;
    wt(1'b0, 50, "over-power fault");
    repeat (8) @(posedge hclk);
    chb(sw, 1'b0, "over-power stop holds");
    over_power_fault <= 1'b0;
    $display("over-power done");
    summarize();
  end
endmodule : tb_tof_fault_top
bind tof_fault_top tof_fault_assertions #(.OPP_CYC(OPP_CYC)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .cs_above_opp(cs_above_opp),
  .voltage_sense_above_hi(voltage_sense_above_hi),
  .voltage_sense_above_lo(voltage_sense_above_lo), .light_load_mode(light_load_mode),
  .burst_wait(burst_wait), .low_side_drive(low_side_drive),
  .high_side_drive(high_side_drive), .fault_bias_en(fault_bias_en),
  .opp_set_high(opp_set_high), .switching_enable(switching_enable),
  .power_limit_top_threshold(power_limit_top_threshold));
`default_nettype wire
